// *** epc_params.svh ***
// Constants for the EPROM program control block
// Function
// - Option byte programs only after software sets the option-unlock bit; a bootload copy over the option address powers it regardless.
// - Watchdog option 1 disables watchdog, 0 enables it.
// - Trigger option 1 edge-only, 0 edge-and-level on interrupt pin and port A 0-3.
// - Pull option 1 connects pull devices on ports A, B, C; 0 disconnects.
// - Port interrupt option 1 disables port A 0-3 interrupts; 0 enables.
// - Oscillator delay option 1 gives 224 cycles, 0 gives 4064 cycles.
// - Low-voltage option 1 enables low-voltage reset; 0 disables it.
// - Bootloader entered at reset release with test voltage and port B line 0 low.
// - Bootloader copies external code: program pass at 1 ms per byte, then verify.
// - Control register bits 7:3 read zero; software keeps them zero.
// - Control bit 2 blocks option byte programming at 0, permits at 1.
// - Latch bit 1 makes EPROM writes capture address and data.
// - Latch bit 1 blocks EPROM reads; 0 allows normal reads.
// - Program bit switches programming power; forced zero unless latch bit set.
`ifndef EPC_PARAMS_SVH
`define EPC_PARAMS_SVH
`define EPC_PCR_ADDR       13'h003e
`define EPC_OPT_ADDR       13'h01ff
`define EPC_BOOT_LO        13'h0000
`define EPC_BIT_UNLOCK     2
`define EPC_BIT_LATCH      1
`define EPC_BIT_PROG       0
`define EPC_PCR_RESET      3'h0
`define EPC_OPT_ERASED     6'h3f
`define EPC_OPT_WDOG       5
`define EPC_OPT_TRIG       4
`define EPC_OPT_PULL       3
`define EPC_OPT_PINT       2
`define EPC_OPT_OSC        1
`define EPC_OPT_LVR        0
`define EPC_OSC_SHORT      12'd224
`define EPC_OSC_LONG       12'd4064
`define EPC_CLK_MHZ        200
`define EPC_BOOT_PGM_US    1000
`define EPC_BOOT_PGM_CYC   (`EPC_BOOT_PGM_US * `EPC_CLK_MHZ)
`define EPC_STRAP_WAIT     3'd4
`endif

// *** epc_pkg.sv ***
// Types for the EPROM program control block
package epc_pkg;
	typedef enum logic [2:0] {
		EPC_B_IDLE = 3'b000,
		EPC_B_READ = 3'b001,
		EPC_B_PROG = 3'b011,
		EPC_B_VRFY = 3'b010,
		EPC_B_DONE = 3'b110,
		EPC_B_FAIL = 3'b111
	} epc_boot_t;
endpackage

// *** epc_sync.sv ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module epc_sync #(
	parameter logic INIT = 1'b0
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	// Data
	input  wire logic din,
	output logic      dout
);
	typedef struct packed {
		logic [2:0] st;
		logic       q;
	} epc_sync_t;
	epc_sync_t s_r, s_nxt;
	always_comb begin
		s_nxt = s_r;
		s_nxt.st = {s_r.st[1:0], din};
		// First stage only feeds the second
		if (s_r.st[1] == s_r.st[2]) begin
			s_nxt.q = s_r.st[2];
		end
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= {{3{INIT}}, INIT};
		end else begin
			s_r <= s_nxt;
		end
	end
	assign dout = s_r.q;
endmodule // epc_sync
`default_nettype wire

// *** epc_eprom_ctrl.sv ***
// EPROM program control, option byte outputs and bootloader copier
`timescale 1ns/10ps
`default_nettype none
`include "epc_params.svh"
module epc_eprom_ctrl
	import epc_pkg::*;
#(
	parameter int          AW          = 13,
	parameter int          BOOT_BYTES  = 2560,
	parameter logic [12:0] BOOT_BASE   = 13'h0000,
	parameter int          PGM_CYC     = `EPC_BOOT_PGM_CYC
) (
	// Clock and reset
	input  wire logic          sys_clk,
	input  wire logic          rst_n,
	// CPU bus
	input  wire logic [AW-1:0] cpu_addr,
	input  wire logic          cpu_wr,
	input  wire logic          cpu_rd,
	input  wire logic [7:0]    cpu_wdata,
	output logic [7:0]         cpu_rdata,
	// Boot strap pins
	input  wire logic          test_voltage_level,
	input  wire logic          port_b_line_0,
	// EPROM array
	output logic [AW-1:0]      arr_addr,
	output logic [7:0]         arr_wdata,
	output logic               arr_read_en,
	output logic               arr_prog_power,
	input  wire logic [7:0]    arr_rdata,
	input  wire logic [7:0]    opt_cell,
	// External EPROM for bootload
	output logic [AW-1:0]      ext_addr,
	output logic               ext_rd,
	input  wire logic [7:0]    ext_rdata,
	// Boot status
	output logic               boot_active,
	output logic               boot_done,
	output logic               boot_error,
	// Option configuration
	output logic               watchdog_enable,
	output logic               edge_only_trigger,
	output logic               pull_devices_on,
	output logic               port_a_int_enable,
	output logic [11:0]        osc_delay_cycles,
	output logic               low_voltage_reset_enable
);
	localparam int CW = $clog2(PGM_CYC + 1);
	typedef struct packed {
		logic            unlock;
		logic            latch;
		logic            prog;
		logic [AW-1:0]   lat_addr;
		logic [7:0]      lat_data;
		logic            lat_opt;
		logic [5:0]      opt;
		logic [7:0]      rdata;
		epc_boot_t       bst;
		logic [AW-1:0]   bidx;
		logic [CW-1:0]   cnt;
		logic            strap_seen;
		logic [2:0]      strap_cnt;
	} epc_state_t;
	epc_state_t s_r, s_nxt;
	logic tst_s, pb0_s;

	// --------------------------------------------------------------
	// Strap synchronisers
	// --------------------------------------------------------------
	// Strap pins are asynchronous; their value is trusted only once the filter settles
	epc_sync #(.INIT(1'b0)) u_sync_tst (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.din     (test_voltage_level),
		.dout    (tst_s)
	);
	epc_sync #(.INIT(1'b1)) u_sync_pb0 (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.din     (port_b_line_0),
		.dout    (pb0_s)
	);

	// --------------------------------------------------------------
	// Address helpers
	// --------------------------------------------------------------
	function automatic logic hit(input logic [AW-1:0] a, input logic [12:0] r);
		return a == AW'(r);
	endfunction

	function automatic logic [AW-1:0] boot_addr(input logic [AW-1:0] idx);
		return AW'(BOOT_BASE) + idx;
	endfunction

	function automatic logic [AW-1:0] next_idx(input logic [AW-1:0] idx);
		return idx + AW'(1);
	endfunction

	// --------------------------------------------------------------
	// Next state
	// --------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.rdata = 8'h00;
		if (s_r.bst == EPC_B_IDLE && !s_r.strap_seen) begin
			// Strap is sampled once, after the three-flop filters have taken the pin level
			if (s_r.strap_cnt != `EPC_STRAP_WAIT) begin
				s_nxt.strap_cnt = s_r.strap_cnt + 3'd1;
			end else begin
				s_nxt.strap_seen = 1'b1;
				if (tst_s && !pb0_s) begin
					s_nxt.bst  = EPC_B_READ;
					s_nxt.bidx = '0;
				end
			end
		end
		unique case (s_r.bst)
			EPC_B_IDLE, EPC_B_DONE, EPC_B_FAIL: begin
				if (cpu_wr && hit(cpu_addr, `EPC_PCR_ADDR)) begin
					s_nxt.unlock = cpu_wdata[`EPC_BIT_UNLOCK];
					s_nxt.latch  = cpu_wdata[`EPC_BIT_LATCH];
					// Program power only with latch already set
					s_nxt.prog = cpu_wdata[`EPC_BIT_PROG] && s_r.latch
						&& cpu_wdata[`EPC_BIT_LATCH];
				end else if (cpu_wr && s_r.latch && !s_r.prog) begin
					s_nxt.lat_addr = cpu_addr;
					s_nxt.lat_data = cpu_wdata;
					s_nxt.lat_opt  = hit(cpu_addr, `EPC_OPT_ADDR);
				end
				if (cpu_rd) begin
					if (hit(cpu_addr, `EPC_PCR_ADDR)) begin
						s_nxt.rdata = {5'h00, s_r.unlock, s_r.latch, s_r.prog};
					end else if (hit(cpu_addr, `EPC_OPT_ADDR)) begin
						s_nxt.rdata = {2'b00, s_r.opt};
					end else if (!s_r.latch) begin
						s_nxt.rdata = arr_rdata;
					end
				end
				// Option cell burns only while unlocked and powered
				if (s_r.prog && s_r.lat_opt && s_r.unlock) begin
					s_nxt.opt = s_r.opt & s_r.lat_data[5:0];
				end
			end
			EPC_B_READ: begin
				s_nxt.lat_addr = boot_addr(s_r.bidx);
				s_nxt.lat_data = ext_rdata;
				s_nxt.cnt      = '0;
				s_nxt.bst      = EPC_B_PROG;
			end
			EPC_B_PROG: begin
				s_nxt.cnt = s_r.cnt + CW'(1);
				if (s_r.cnt == CW'(PGM_CYC - 1)) begin
					if (s_r.bidx == AW'(BOOT_BYTES - 1)) begin
						s_nxt.bidx = '0;
						s_nxt.bst  = EPC_B_VRFY;
					end else begin
						s_nxt.bidx = next_idx(s_r.bidx);
						s_nxt.bst  = EPC_B_READ;
					end
				end
			end
			EPC_B_VRFY: begin
				if (arr_rdata != ext_rdata) begin
					s_nxt.bst = EPC_B_FAIL;
				end else if (s_r.bidx == AW'(BOOT_BYTES - 1)) begin
					s_nxt.bst = EPC_B_DONE;
				end else begin
					s_nxt.bidx = next_idx(s_r.bidx);
				end
			end
			default: begin
				// Unused codes land in the error state so a corrupt state shows
				s_nxt.bst = EPC_B_FAIL;
			end
		endcase
	end

	// --------------------------------------------------------------
	// State register
	// --------------------------------------------------------------
	// Option bits come back erased on every reset; nothing here is nonvolatile
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r            <= '0;
			s_r.unlock     <= 1'(`EPC_PCR_RESET >> `EPC_BIT_UNLOCK);
			s_r.opt        <= `EPC_OPT_ERASED;
			s_r.bst        <= EPC_B_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// --------------------------------------------------------------
	// Outputs
	// --------------------------------------------------------------
	logic boot_prog;
	assign boot_prog      = s_r.bst == EPC_B_PROG;
	assign cpu_rdata      = s_r.rdata;
	// Verify reads the array at the copy index while the CPU is locked out
	assign arr_addr       = (s_r.bst == EPC_B_VRFY) ? boot_addr(s_r.bidx)
		: (s_r.latch || boot_prog) ? s_r.lat_addr : cpu_addr;
	assign arr_wdata      = s_r.lat_data;
	assign arr_read_en    = !s_r.latch && !boot_prog;
	// Outside bootload, option cell power is kept off when locked
	assign arr_prog_power = boot_prog
		|| (s_r.prog && s_r.latch && (!s_r.lat_opt || s_r.unlock));
	assign ext_addr       = boot_addr(s_r.bidx);
	assign ext_rd         = s_r.bst == EPC_B_READ || s_r.bst == EPC_B_VRFY;
	assign boot_active    = s_r.bst inside {EPC_B_READ, EPC_B_PROG, EPC_B_VRFY};
	assign boot_done      = s_r.bst == EPC_B_DONE;
	assign boot_error     = s_r.bst == EPC_B_FAIL;
	// Cell opt_cell is the erased array image; the live copy is s_r.opt
	logic [5:0] ob;
	assign ob = s_r.opt & opt_cell[5:0];
	assign watchdog_enable          = !ob[`EPC_OPT_WDOG];
	assign edge_only_trigger        = ob[`EPC_OPT_TRIG];
	assign pull_devices_on          = ob[`EPC_OPT_PULL];
	assign port_a_int_enable        = !ob[`EPC_OPT_PINT];
	assign osc_delay_cycles         = ob[`EPC_OPT_OSC] ? `EPC_OSC_SHORT : `EPC_OSC_LONG;
	assign low_voltage_reset_enable = ob[`EPC_OPT_LVR];
endmodule // epc_eprom_ctrl
`default_nettype wire

// *** epc_ext_eprom.sv ***
// External EPROM model that feeds the bootload copier
`timescale 1ns/10ps
`default_nettype none
module epc_ext_eprom (
	// Clock
	input  wire logic        sys_clk,
	// Read port
	input  wire logic [12:0] ext_addr,
	input  wire logic        ext_rd,
	output logic [7:0]       ext_rdata
);
	logic [7:0] last_r = 8'h00;
	// Byte depends on its address so a shifted copy shows; idle bus is inverted
	assign ext_rdata = ext_rd ? (ext_addr[7:0] ^ 8'h5a) : ~last_r;
	always @(posedge sys_clk)
		if (ext_rd)
			last_r <= ext_addr[7:0] ^ 8'h5a;
endmodule // epc_ext_eprom
`default_nettype wire

// *** epc_eprom_ctrl_asserts.sv ***
// Port checker for the EPROM program control block
`timescale 1ns/10ps
`default_nettype none
`include "epc_params.svh"
module epc_eprom_ctrl_asserts #(
	parameter int AW = 13
) (
	// Clock and CPU side
	input wire logic          sys_clk,
	input wire logic          rst_n,
	input wire logic [AW-1:0] cpu_addr,
	input wire logic          cpu_wr,
	input wire logic          cpu_rd,
	input wire logic [7:0]    cpu_wdata,
	input wire logic [7:0]    cpu_rdata,
	// Array and status
	input wire logic [AW-1:0] arr_addr,
	input wire logic [7:0]    arr_wdata,
	input wire logic          arr_read_en,
	input wire logic          arr_prog_power,
	input wire logic          boot_active,
	// Option outputs
	input wire logic          watchdog_enable,
	input wire logic          edge_only_trigger,
	input wire logic          pull_devices_on,
	input wire logic          port_a_int_enable,
	input wire logic [11:0]   osc_delay_cycles,
	input wire logic          low_voltage_reset_enable
);
	logic pcr_wr;
	logic arr_wr;
	assign pcr_wr = cpu_wr && cpu_addr == `EPC_PCR_ADDR && !boot_active;
	assign arr_wr = cpu_wr && cpu_addr != `EPC_PCR_ADDR && !boot_active;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_rst; $rose(rst_n) |-> arr_read_en && !arr_prog_power; endproperty
	a_rst: assert property (p_rst) else $error("array not idle after reset");
	property p_rd0; cpu_rd && cpu_addr == `EPC_PCR_ADDR |=> cpu_rdata[7:3] == 5'h00; endproperty
	a_rd0: assert property (p_rd0) else $error("reserved control bits not zero");
	property p_lock;
		cpu_rd && !arr_read_en && !boot_active && cpu_addr != `EPC_PCR_ADDR
			&& cpu_addr != `EPC_OPT_ADDR |=> cpu_rdata == 8'h00;
	endproperty
	a_lock: assert property (p_lock) else $error("array readable while latched");
	property p_nopgm; pcr_wr && arr_read_en && cpu_wdata[0] |=> !arr_prog_power; endproperty
	a_nopgm: assert property (p_nopgm) else $error("power without latch");
	property p_clr; pcr_wr && !cpu_wdata[1] |=> arr_read_en && !arr_prog_power; endproperty
	a_clr: assert property (p_clr) else $error("latch clear not honoured");
	property p_cap;
		arr_wr && !arr_read_en && !arr_prog_power
			|=> arr_wdata == $past(cpu_wdata) && arr_addr == $past(cpu_addr);
	endproperty
	a_cap: assert property (p_cap) else $error("write not latched");
	property p_pwr; arr_prog_power && !boot_active |-> !arr_read_en; endproperty
	a_pwr: assert property (p_pwr) else $error("power while readable");
	property p_stab;
		!arr_prog_power && !$past(arr_prog_power) |-> $stable({watchdog_enable,
			edge_only_trigger, pull_devices_on, port_a_int_enable, low_voltage_reset_enable});
	endproperty
	a_stab: assert property (p_stab) else $error("option outputs moved");
	property p_osc;
		osc_delay_cycles == `EPC_OSC_SHORT || osc_delay_cycles == `EPC_OSC_LONG;
	endproperty
	a_osc: assert property (p_osc) else $error("bad oscillator delay");
	c_pwr: cover property (arr_prog_power && !boot_active);
	c_boot: cover property (arr_prog_power && boot_active);
	c_lock: cover property (cpu_rd && !arr_read_en);
endmodule // epc_eprom_ctrl_asserts
bind epc_eprom_ctrl epc_eprom_ctrl_asserts #(.AW(AW)) u_epc_eprom_ctrl_asserts (.sys_clk,
	.rst_n, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata, .arr_addr, .arr_wdata,
	.arr_read_en, .arr_prog_power, .boot_active, .watchdog_enable, .edge_only_trigger,
	.pull_devices_on, .port_a_int_enable, .osc_delay_cycles, .low_voltage_reset_enable);
`default_nettype wire

// *** epc_eprom_ctrl_tb_top.sv ***
// Self-checking bench for the EPROM program control block
`timescale 1ns/10ps
`default_nettype none
`include "epc_params.svh"
module epc_eprom_ctrl_tb_top;
	logic        sys_clk = 1'b0, rst_n = 1'b0, cpu_wr = 1'b0, cpu_rd = 1'b0, rd_d = 1'b0;
	logic        test_voltage_level = 1'b0, port_b_line_0 = 1'b1;
	logic [12:0] cpu_addr = 13'h0000, arr_addr, ext_addr;
	logic [7:0]  cpu_wdata = 8'h00, cpu_rdata, arr_wdata, arr_rdata, ext_rdata, rnd;
	logic        arr_read_en, arr_prog_power, ext_rd, boot_active, boot_done, boot_error;
	logic        watchdog_enable, edge_only_trigger, pull_devices_on, port_a_int_enable;
	logic        low_voltage_reset_enable;
	logic [11:0] osc_delay_cycles;
	logic [5:0]  opt;
	logic [7:0]  mem [0:8191];
	logic [7:0]  exp_q [$];
	int          num_errors = 0, check_count = 0, pwr_cnt = 0, i;
	epc_eprom_ctrl #(.BOOT_BYTES(3), .PGM_CYC(4)) u_epc_eprom_ctrl (.sys_clk, .rst_n,
		.cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata, .test_voltage_level,
		.port_b_line_0, .arr_addr, .arr_wdata, .arr_read_en, .arr_prog_power, .arr_rdata,
		.opt_cell(8'hff), .ext_addr, .ext_rd, .ext_rdata, .boot_active, .boot_done,
		.boot_error, .watchdog_enable, .edge_only_trigger, .pull_devices_on,
		.port_a_int_enable, .osc_delay_cycles, .low_voltage_reset_enable);
	epc_ext_eprom u_epc_ext_eprom (.sys_clk, .ext_addr, .ext_rd, .ext_rdata);
	// Cells only clear bits while powered; a locked array must not leak its data
	assign arr_rdata = arr_read_en ? mem[arr_addr] : ~mem[arr_addr];
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic chk(input string n, input logic [11:0] e, g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		cpu_addr <= a;
		cpu_wdata <= d;
		cpu_wr <= 1'b1;
		@(posedge sys_clk);
		cpu_wr <= 1'b0;
	endtask
	task automatic rd(input logic [12:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		cpu_addr <= a;
		cpu_rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge sys_clk);
		cpu_rd <= 1'b0;
	endtask
	task automatic do_reset(input logic t, b);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		test_voltage_level <= t;
		port_b_line_0 <= b;
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
	endtask
	task automatic cfg();
		chk("option outputs", {7'h00, ~opt[5], opt[4], opt[3], ~opt[2], opt[0]}, {7'h00,
			watchdog_enable, edge_only_trigger, pull_devices_on, port_a_int_enable,
			low_voltage_reset_enable});
		chk("osc_delay_cycles", opt[1] ? `EPC_OSC_SHORT : `EPC_OSC_LONG, osc_delay_cycles);
	endtask
	task automatic boot_run(input logic fail);
		int n;
		do_reset(1'b1, 1'b0);
		for (n = 0; n < 400 && boot_done !== 1'b1 && boot_error !== 1'b1; n++)
			@(posedge sys_clk);
		chk("boot_done", {11'h000, ~fail}, {11'h000, boot_done});
		chk("boot_error", {11'h000, fail}, {11'h000, boot_error});
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		foreach (mem[k])
			mem[k] = 8'hff;
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (arr_prog_power)
			mem[arr_addr] <= mem[arr_addr] & arr_wdata;
		if (arr_prog_power && boot_active)
			pwr_cnt++;
		if (rd_d)
			chk("cpu_rdata", exp_q.size() ? {4'h0, exp_q.pop_front()} : 12'hxxx, {4'h0, cpu_rdata});
		rd_d <= cpu_rd;
	end
	initial begin
		rnd = 8'h19;
		opt = 6'h3f;
		do_reset(1'b0, 1'b1);
		rd(`EPC_PCR_ADDR, 8'h00);
		rd(`EPC_OPT_ADDR, 8'h3f);
		cfg();
		wr(`EPC_PCR_ADDR, 8'hf8);
		rd(`EPC_PCR_ADDR, 8'h00);
		wr(`EPC_PCR_ADDR, 8'hff);
		rd(`EPC_PCR_ADDR, 8'h06);
		wr(`EPC_PCR_ADDR, 8'h00);
		$display("control register test done");
		// Even passes leave the unlock bit clear, so the option byte must hold
		for (i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			// Programming supply is taken as present for this whole loop
			wr(`EPC_PCR_ADDR, {5'h00, i[0], 2'b10});
			rd(13'h0100 + 13'(i), 8'h00);
			wr(`EPC_OPT_ADDR, rnd);
			wr(`EPC_PCR_ADDR, {5'h00, i[0], 2'b11});
			repeat (4) @(posedge sys_clk);
			wr(`EPC_PCR_ADDR, {5'h00, i[0], 2'b10});
			wr(`EPC_PCR_ADDR, 8'h00);
			if (i[0])
				opt = opt & rnd[5:0];
			rd(`EPC_OPT_ADDR, {2'b00, opt});
			cfg();
		end
		$display("option programming test done");
		boot_run(1'b0);
		chk("boot power cycles", 12'h00c, 12'(pwr_cnt));
		for (i = 0; i < 3; i++)
			rd(13'(i), 8'(i) ^ 8'h5a);
		repeat (2) @(posedge sys_clk);
		$display("bootload test done");
		// A cleared cell that the image needs set must end the copy in the error state
		mem[1] = 8'h00;
		boot_run(1'b1);
		$display("bootload verify failure test done");
		stop_test();
	end
endmodule // epc_eprom_ctrl_tb_top
`default_nettype wire
